//--- inc/dit_pkg.sv
/*
  Constants, opcode map, cycle counts, field positions and carrier types
  for the instruction decode and issue block.
  Assumes a 24-bit program word and one instruction cycle per mclk rising edge.
*/
`default_nettype none

package dit_pkg;

  // Word geometry
  localparam int OPC_LSB         = 16;
  localparam int OPC_W           = 8;

  // Opcode map; zero in the top byte means no-operation, except on the partner word of a two-word instruction
  localparam logic [7:0] OPC_NOP             = 8'h00;
  localparam logic [7:0] OPC_JUMP_INDIRECT   = 8'h01;
  localparam logic [7:0] OPC_CALL_ABS        = 8'h02;
  localparam logic [7:0] OPC_CALL_INDIRECT   = 8'h03;
  localparam logic [7:0] OPC_ABS_JUMP        = 8'h04;
  localparam logic [7:0] OPC_RETURN          = 8'h06;
  localparam logic [7:0] OPC_INTERRUPT_EXIT  = 8'h07;
  localparam logic [7:0] OPC_LOOP_SETUP      = 8'h08;
  localparam logic [7:0] OPC_REL_JUMP_ALWAYS = 8'h37;
  localparam logic [3:0] OPC_REL_JUMP_GROUP  = 4'h3;
  localparam logic [7:0] OPC_SKIP_BIT_CLR    = 8'ha6;
  localparam logic [7:0] OPC_SKIP_BIT_SET    = 8'ha7;
  localparam logic [7:0] OPC_TABLE_RD        = 8'hba;
  localparam logic [7:0] OPC_TABLE_WR        = 8'hbb;
  localparam logic [7:0] OPC_MOVE_DOUBLE     = 8'hbe;
  localparam logic [7:0] OPC_SKIP_CMP_EQ     = 8'he6;
  localparam logic [7:0] OPC_SKIP_CMP_NE     = 8'he7;

  // Instruction cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Operand field positions (LSB of each field)
  localparam int BIT_POS_LSB   = 12;
  localparam int FILE_LSB      = 0;
  localparam int LIT_LSB       = 4;
  localparam int LIT14_LSB     = 0;
  localparam int BYTE_MODE_BIT = 14;
  localparam int ACC_BIT       = 15;
  localparam int AWB_LSB       = 0;
  localparam int DEFAULT_WORKING_REGISTER_DEST_BIT = 13;
  localparam int BASE_LSB      = 11;
  localparam int SRC_LSB       = 0;
  localparam int DST_LSB       = 7;
  localparam int XPF_LSB       = 10;
  localparam int YPF_LSB       = 2;
  localparam int XD_LSB        = 8;
  localparam int YD_LSB        = 6;
  localparam int MUL_LSB       = 12;
  localparam int SQUARE_BIT    = 15;
  localparam int PADDR_LO_LSB  = 1;
  localparam int PADDR_HI_LSB  = 0;

  // Working register numbers
  localparam logic [3:0] REG_DEFAULT_WORKING_REGISTER      = 4'h0;
  localparam logic [3:0] REG_PF_BASE   = 4'h4;
  localparam logic [3:0] REG_X_LO      = 4'h8;
  localparam logic [3:0] REG_X_HI      = 4'h9;
  localparam logic [3:0] REG_Y_LO      = 4'ha;
  localparam logic [3:0] REG_Y_HI      = 4'hb;
  localparam logic [3:0] REG_INDEX     = 4'hc;
  localparam logic [3:0] REG_WRITEBACK = 4'hd;
  localparam logic [2:0] AWB_POST_INC  = 3'h2;

  typedef enum logic [3:0] {
    CLS_PLAIN       = 4'h0,
    CLS_NOP         = 4'h1,
    CLS_TWO_WORD    = 4'h2,
    CLS_COND_JUMP   = 4'h3,
    CLS_BRANCH      = 4'h4,
    CLS_TABLE       = 4'h5,
    CLS_RETURN      = 4'h6,
    CLS_MOVE_DOUBLE = 4'h7,
    CLS_SKIP        = 4'h8
  } dit_class_t;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'h0,
    ST_SECOND = 3'h1,
    ST_STALL  = 3'h2,
    ST_SKIP   = 3'h3,
    ST_SKIP2  = 3'h4
  } dit_state_t;

  typedef struct packed {
    logic       enable;
    logic [3:0] addr_reg;
    logic       indexed;
    logic [3:0] post_mod;
    logic [3:0] dest_reg;
  } dit_prefetch_t;

  typedef struct packed {
    logic [3:0]    bit_position_field;
    logic [12:0]   file_addr;
    logic          lit1;
    logic [3:0]    lit4;
    logic [4:0]    lit5;
    logic [7:0]    lit8;
    logic [13:0]   lit14;
    logic [15:0]   lit16;
    logic [9:0]    unsigned_ten_bit_literal;
    logic [15:0]   signed_ten_bit_literal;
    logic [15:0]   slit6;
    logic [15:0]   slit16;
    logic [22:0]   program_address_literal;
    logic          acc_sel;
    logic          awb_en;
    logic          awb_indirect;
    logic [3:0]    accumulator_writeback_target;
    logic [2:0]    awb_post_inc;
    logic          file_to_default_working_register;
    logic [3:0]    default_working_register;
    logic [3:0]    base_working_register;
    logic [3:0]    src_reg;
    logic [3:0]    dst_reg;
    dit_prefetch_t x_prefetch_address;
    dit_prefetch_t y_prefetch_address;
    logic [3:0]    mul_a;
    logic [3:0]    mul_b;
    logic          mul_bad;
  } dit_operands_t;

  typedef struct packed {
    logic          valid;
    logic          nop;
    logic          write_en;
    logic [7:0]    opcode;
    logic [1:0]    cycle_index;
    logic [1:0]    cycles;
    logic          pc_change;
    logic          second_word_bad;
    dit_operands_t operands;
  } dit_issue_t;

endpackage

`default_nettype wire

//--- src/dit_decoder.sv
/*
  Instruction decode and issue sequencer: takes 24-bit program words from
  the fetch path, joins two-word instructions, decodes operand fields and
  issues one slot per instruction cycle, padding with no-operation slots.
  Assumes the fetch path holds fetch_word stable while fetch_valid is high
  and not taken, and that cond_true is the core's test result for the word
  being offered in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Two-word instruction uses 48 bits; second word's top eight bits are zero.
// - A lone second word decodes as a no-operation.
// - Plain one-word instruction without taken test or jump takes one cycle.
// - True test or program counter change takes two cycles, extra one empty; returns and skips over two words take three.
// - Branches, indirect jumps, table accesses and returns take two or three cycles.
// - Taken skip costs two cycles over one word, three over two words.
// - Double-word move takes two cycles.
// - Every two-word instruction executes in two cycles.
// - Each word is 24 bits, top byte is the opcode, rest operands.
// - Bit position field is four bits, selecting bit 0 to 15.
// - Direct file address spans zero to 0x1fff.
// - Unsigned literals are 1, 4, 5, 8, 14 and 16 bits wide.
// - Ten-bit unsigned literal limited to 0..255 in byte mode, 0..1023 otherwise.
// - Program address literal has its lowest bit forced to zero.
// - Signed 6, 10 and 16-bit literals are two's complement, sign-extended.
// - Accumulator selector picks exactly one of A or B.
// - Writeback goes to register 13 or its location, post-incremented by two.
// - File instructions naming the default register use register zero.
// - Base, source and destination fields select one of sixteen registers.
// - X prefetch via register 8 or 9, modifiers, 9 indexed by 12, or none.
// - Y prefetch via register 10 or 11, same modifiers, 11 indexed, or none.
// - Prefetch destinations are registers 4 through 7 only.
// - Multiply operands from registers 4..7: six pairs or one squared.

module dit_decoder (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Fetch path
  input  wire logic         fetch_valid,
  input  wire logic [23:0]  fetch_word,
  output logic              fetch_ready,
  // Core condition result for the offered word
  input  wire logic         cond_true,
  // Issue slot towards execute
  output dit_pkg::dit_issue_t issue
);
  import dit_pkg::*;

  dit_state_t    state;
  logic [1:0]    extra;
  logic [23:0]   first_word;
  logic          take;
  logic [7:0]    cur_opc;
  dit_class_t    cur_class;
  logic [1:0]    cur_cycles;

  // Opcode to timing class; a zero top byte is a no-operation
  function automatic dit_class_t classify(input logic [7:0] opc);
    dit_class_t c;
    c = CLS_PLAIN;
    case (opc)
      OPC_NOP: c = CLS_NOP;
      OPC_CALL_ABS, OPC_ABS_JUMP, OPC_LOOP_SETUP: c = CLS_TWO_WORD;
      OPC_JUMP_INDIRECT, OPC_CALL_INDIRECT, OPC_REL_JUMP_ALWAYS: c = CLS_BRANCH;
      OPC_TABLE_RD, OPC_TABLE_WR: c = CLS_TABLE;
      OPC_RETURN, OPC_INTERRUPT_EXIT: c = CLS_RETURN;
      OPC_MOVE_DOUBLE: c = CLS_MOVE_DOUBLE;
      OPC_SKIP_BIT_CLR, OPC_SKIP_BIT_SET, OPC_SKIP_CMP_EQ, OPC_SKIP_CMP_NE: c = CLS_SKIP;
      default: begin
        if (opc[7:4] == OPC_REL_JUMP_GROUP) begin
          c = CLS_COND_JUMP;
        end
      end
    endcase
    return c;
  endfunction

  // Instruction cycles charged at issue; skips add one more over two words
  function automatic logic [1:0] instr_cycles(input dit_class_t c, input logic cond);
    logic [1:0] n;
    n = CYC_ONE;
    case (c)
      CLS_COND_JUMP, CLS_SKIP: n = cond ? CYC_TWO : CYC_ONE;
      CLS_BRANCH, CLS_TABLE: n = CYC_TWO;
      CLS_RETURN: n = CYC_THREE;
      CLS_MOVE_DOUBLE: n = CYC_TWO;
      CLS_TWO_WORD: n = CYC_TWO;
      default: n = CYC_ONE;
    endcase
    return n;
  endfunction

  // Program counter leaves its sequential path
  function automatic logic changes_pc(input dit_class_t c, input logic cond,
                                      input logic [7:0] opc);
    logic r;
    r = 1'b0;
    case (c)
      CLS_COND_JUMP: r = cond;
      CLS_BRANCH, CLS_RETURN: r = 1'b1;
      CLS_TWO_WORD: r = (opc != OPC_LOOP_SETUP);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Registers 4..7 from a two-bit selector
  function automatic logic [3:0] reg_4to7(input logic [1:0] sel);
    return REG_PF_BASE | {2'h0, sel};
  endfunction

  // Prefetch code: bit 3 picks the high register, low bits the modifier
  function automatic dit_prefetch_t decode_prefetch(input logic [3:0] code,
                                                    input logic [1:0] dsel,
                                                    input logic [3:0] lo,
                                                    input logic [3:0] hi);
    dit_prefetch_t p;
    p          = '0;
    p.enable   = 1'b1;
    p.addr_reg = code[3] ? hi : lo;
    p.dest_reg = reg_4to7(dsel);
    case (code[2:0])
      3'h0: p.post_mod = 4'h0;
      3'h1: p.post_mod = 4'h2;
      3'h2: p.post_mod = 4'h4;
      3'h3: p.post_mod = 4'h6;
      3'h5: p.post_mod = 4'ha;
      3'h6: p.post_mod = 4'hc;
      3'h7: p.post_mod = 4'he;
      default: begin
        // Code 4 on the low register means no prefetch at all
        p.post_mod = 4'h0;
        p.indexed  = code[3];
        p.enable   = code[3];
      end
    endcase
    return p;
  endfunction

  // Operand fields; every field is extracted, execute uses what it needs
  function automatic dit_operands_t decode_operands(input logic [23:0] w,
                                                    input logic [23:0] w2);
    dit_operands_t o;
    logic [9:0]    l10;
    logic [2:0]    mm;
    o   = '0;
    l10 = w[LIT_LSB +: 10];
    mm  = w[MUL_LSB +: 3];
    o.bit_position_field = w[BIT_POS_LSB +: 4];
    o.file_addr          = w[FILE_LSB +: 13];
    o.lit1               = w[LIT_LSB];
    o.lit4               = w[LIT_LSB +: 4];
    o.lit5               = w[LIT_LSB +: 5];
    o.lit8               = w[LIT_LSB +: 8];
    o.lit14              = w[LIT14_LSB +: 14];
    o.lit16              = w[LIT_LSB +: 16];
    // Byte mode keeps only the low eight bits of the ten-bit literal
    o.unsigned_ten_bit_literal = w[BYTE_MODE_BIT] ? {2'h0, l10[7:0]} : l10;
    o.signed_ten_bit_literal   = {{6{l10[9]}}, l10};
    o.slit6  = {{10{w[LIT_LSB + 5]}}, w[LIT_LSB +: 6]};
    o.slit16 = w[LIT_LSB +: 16];
    // Bit zero is forced low so odd program addresses cannot issue
    o.program_address_literal = {w2[PADDR_HI_LSB +: 7], w[PADDR_LO_LSB +: 15], 1'b0};
    o.acc_sel = w[ACC_BIT];
    case (w[AWB_LSB +: 2])
      2'h1: o.awb_en = 1'b1;
      2'h2: begin
        o.awb_en       = 1'b1;
        o.awb_indirect = 1'b1;
        o.awb_post_inc = AWB_POST_INC;
      end
      default: o.awb_en = 1'b0;
    endcase
    o.accumulator_writeback_target = REG_WRITEBACK;
    o.file_to_default_working_register             = ~w[DEFAULT_WORKING_REGISTER_DEST_BIT];
    o.default_working_register = REG_DEFAULT_WORKING_REGISTER;
    o.base_working_register    = w[BASE_LSB +: 4];
    o.src_reg                  = w[SRC_LSB +: 4];
    o.dst_reg                  = w[DST_LSB +: 4];
    o.x_prefetch_address = decode_prefetch(w[XPF_LSB +: 4], w[XD_LSB +: 2],
                                           REG_X_LO, REG_X_HI);
    o.y_prefetch_address = decode_prefetch(w[YPF_LSB +: 4], w[YD_LSB +: 2],
                                           REG_Y_LO, REG_Y_HI);
    // Squares use one register twice, otherwise one of six distinct pairs
    if (w[SQUARE_BIT]) begin
      o.mul_a = reg_4to7(mm[1:0]);
      o.mul_b = reg_4to7(mm[1:0]);
    end else begin
      case (mm)
        3'h0: begin o.mul_a = reg_4to7(2'h0); o.mul_b = reg_4to7(2'h1); end
        3'h1: begin o.mul_a = reg_4to7(2'h0); o.mul_b = reg_4to7(2'h2); end
        3'h2: begin o.mul_a = reg_4to7(2'h0); o.mul_b = reg_4to7(2'h3); end
        3'h3: begin o.mul_a = reg_4to7(2'h1); o.mul_b = reg_4to7(2'h2); end
        3'h4: begin o.mul_a = reg_4to7(2'h1); o.mul_b = reg_4to7(2'h3); end
        3'h5: begin o.mul_a = reg_4to7(2'h2); o.mul_b = reg_4to7(2'h3); end
        default: o.mul_bad = 1'b1;
      endcase
    end
    return o;
  endfunction

  // Offered word decode; fetch stalls only while padding slots issue
  assign cur_opc     = fetch_word[OPC_LSB +: OPC_W];
  assign cur_class   = classify(cur_opc);
  assign cur_cycles  = instr_cycles(cur_class, cond_true);
  assign fetch_ready = (state != ST_STALL);
  assign take        = fetch_valid & fetch_ready;

  // Sequencer state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_FETCH;
    end else begin
      case (state)
        ST_FETCH: begin
          if (take) begin
            if (cur_class == CLS_TWO_WORD) begin
              state <= ST_SECOND;
            end else if (cur_class == CLS_SKIP && cond_true) begin
              state <= ST_SKIP;
            end else if (cur_cycles != CYC_ONE) begin
              state <= ST_STALL;
            end
          end
        end
        ST_SECOND: begin
          if (take) begin
            state <= ST_FETCH;
          end
        end
        ST_STALL: begin
          if (extra == CYC_ONE) begin
            state <= ST_FETCH;
          end
        end
        ST_SKIP: begin
          if (take) begin
            state <= (cur_class == CLS_TWO_WORD) ? ST_SKIP2 : ST_FETCH;
          end
        end
        ST_SKIP2: begin
          if (take) begin
            state <= ST_FETCH;
          end
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  // Padding slots still owed after the real slot
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      extra <= 2'h0;
    end else if (state == ST_FETCH && take) begin
      extra <= cur_cycles - CYC_ONE;
    end else if (state == ST_STALL) begin
      extra <= extra - CYC_ONE;
    end
  end

  // First half of a two-word instruction waits here for its partner
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      first_word <= 24'h0;
    end else if (state == ST_FETCH && take && cur_class == CLS_TWO_WORD) begin
      first_word <= fetch_word;
    end
  end

  // Issue slot; padding slots never carry a write enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      issue <= '0;
    end else begin
      issue <= '0;
      case (state)
        ST_FETCH: begin
          if (take && cur_class == CLS_TWO_WORD) begin
            issue.valid  <= 1'b1;
            issue.nop    <= 1'b1;
            issue.opcode <= cur_opc;
            issue.cycles <= CYC_TWO;
          end else if (take) begin
            issue.valid     <= 1'b1;
            issue.nop       <= (cur_class == CLS_NOP);
            issue.write_en  <= (cur_class != CLS_NOP);
            issue.opcode    <= cur_opc;
            issue.cycles    <= cur_cycles;
            issue.pc_change <= changes_pc(cur_class, cond_true, cur_opc);
            issue.operands  <= decode_operands(fetch_word, 24'h0);
          end
        end
        ST_SECOND: begin
          if (take) begin
            issue.valid           <= 1'b1;
            issue.write_en        <= 1'b1;
            issue.opcode          <= first_word[OPC_LSB +: OPC_W];
            issue.cycle_index     <= 2'h1;
            issue.cycles          <= CYC_TWO;
            issue.pc_change       <= changes_pc(CLS_TWO_WORD, 1'b0,
                                                first_word[OPC_LSB +: OPC_W]);
            // Partner word must carry a zero top byte
            issue.second_word_bad <= (cur_opc != OPC_NOP);
            issue.operands        <= decode_operands(first_word, fetch_word);
          end
        end
        ST_STALL: begin
          issue.valid       <= 1'b1;
          issue.nop         <= 1'b1;
          issue.opcode      <= issue.opcode;
          issue.cycle_index <= issue.cycle_index + 2'h1;
          issue.cycles      <= issue.cycles;
        end
        ST_SKIP: begin
          if (take) begin
            issue.valid       <= 1'b1;
            issue.nop         <= 1'b1;
            issue.opcode      <= cur_opc;
            issue.cycle_index <= 2'h1;
            issue.cycles      <= (cur_class == CLS_TWO_WORD) ? CYC_THREE : CYC_TWO;
          end
        end
        ST_SKIP2: begin
          if (take) begin
            issue.valid       <= 1'b1;
            issue.nop         <= 1'b1;
            issue.opcode      <= issue.opcode;
            issue.cycle_index <= 2'h2;
            issue.cycles      <= CYC_THREE;
          end
        end
        default: issue <= '0;
      endcase
    end
  end

  // Checks on slot timing and operand ranges
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence real_slot;
    issue.valid && !issue.nop;
  endsequence

  sequence pad_slot;
    issue.valid && issue.nop && !issue.write_en;
  endsequence

  sequence word_taken(dit_class_t c);
    state == ST_FETCH && take && cur_class == c;
  endsequence

  partner_check_a: assert property (
    state == ST_SECOND && take && cur_opc != OPC_NOP |=> real_slot ##0 issue.second_word_bad)
    else $error("bad partner word not flagged");
  lone_partner_a: assert property (
    state == ST_FETCH && take && cur_opc == OPC_NOP |=> issue.nop && !issue.write_en)
    else $error("zero top byte did not decode as no-operation");
  plain_single_a: assert property (
    word_taken(CLS_PLAIN) |=> real_slot ##0 state == ST_FETCH ##0 issue.cycles == CYC_ONE)
    else $error("plain instruction not single cycle");
  taken_jump_a: assert property (
    word_taken(CLS_COND_JUMP) and cond_true |=> real_slot ##1 pad_slot ##0 state == ST_FETCH)
    else $error("taken jump not two cycles");
  return_three_a: assert property (
    word_taken(CLS_RETURN) |=> real_slot ##1 pad_slot [*2] ##0 state == ST_FETCH)
    else $error("return not three cycles");
  skip_one_word_a: assert property (
    state == ST_SKIP && take && cur_class != CLS_TWO_WORD
      |=> pad_slot ##0 issue.cycles == CYC_TWO ##0 state == ST_FETCH)
    else $error("skip over one word not two cycles");
  skip_two_word_a: assert property (
    state == ST_SKIP && take && cur_class == CLS_TWO_WORD
      |=> pad_slot ##0 state == ST_SKIP2 ##1 (!take or (pad_slot and issue.cycle_index == 2'h2)))
    else $error("skip over two words not three cycles");
  move_double_a: assert property (
    word_taken(CLS_MOVE_DOUBLE) |=> real_slot ##1 pad_slot ##0 state == ST_FETCH)
    else $error("double move not two cycles");
  two_word_join_a: assert property (
    word_taken(CLS_TWO_WORD) |=> pad_slot ##0 state == ST_SECOND ##0 issue.cycle_index == 2'h0)
    else $error("two-word first half not padded");
  even_address_a: assert property (
    real_slot |-> !issue.operands.program_address_literal[0])
    else $error("odd program address issued");
  prefetch_dest_a: assert property (
    real_slot |-> issue.operands.x_prefetch_address.dest_reg[3:2] == 2'h1
                 && issue.operands.y_prefetch_address.dest_reg[3:2] == 2'h1)
    else $error("prefetch destination outside 4..7");
  stall_quiet_a: assert property (
    state == ST_STALL |-> !fetch_ready ##1 pad_slot)
    else $error("stall cycle wrote or fetched");

endmodule

`default_nettype wire

//--- verification/dit_fetch_model.sv
/*
  Behavioural program fetch path feeding the decoder one word at a time.
  Assumes the bench queues words through push and that mclk is the
  instruction clock; lines are driven on the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none

module dit_fetch_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Fetch handshake
  input  wire logic        fetch_ready,
  output logic             fetch_valid,
  output logic [23:0]      fetch_word,
  output logic             cond_true
);
  logic [24:0] q [$];
  logic        taken = 1'b0;

  initial begin
    fetch_valid = 1'b0;
    fetch_word  = 24'h000000;
    cond_true   = 1'b0;
  end

  // Word with its test result in the top bit
  task automatic push(input logic [23:0] w, input logic c);
    q.push_back({c, w});
  endtask

  // Take is only known at the rising edge
  always @(posedge mclk) begin
    taken <= fetch_valid && fetch_ready && !sys_rst;
  end

  // Hold each 24-bit word until taken; idle lines toggle, not stale
  always @(negedge mclk) begin
    if (taken && q.size() > 0) begin
      q.delete(0);
    end
    if (q.size() > 0) begin
      fetch_valid = 1'b1;
      {cond_true, fetch_word} = q[0];
    end else begin
      fetch_valid = 1'b0;
      fetch_word  = ~fetch_word;
      cond_true   = ~cond_true;
    end
  end
endmodule

`default_nettype wire

//--- verification/dsc_instruction_timing_operands_bench.sv
/*
  Self-checking bench for the decode and issue sequencer.
  Assumes dit_pkg is compiled first and the fetch model drives the words.
*/
`timescale 1ns/1ns
`default_nettype none

module dsc_instruction_timing_operands_bench;
  import dit_pkg::*;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        fetch_valid;
  logic        fetch_ready;
  logic        cond_true;
  logic [23:0] fetch_word;
  dit_issue_t  issue;
  dit_issue_t  slots [$];
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;

  always #5 mclk = ~mclk;

  dit_decoder uut (.mclk(mclk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .cond_true(cond_true),
    .issue(issue));
  dit_fetch_model fm (.mclk(mclk), .sys_rst(sys_rst), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .cond_true(cond_true));

  // Collect slots once flops settle; ceiling well above the run length
  always @(posedge mclk) begin
    #1;
    cyc++;
    if (issue.valid === 1'b1) slots.push_back(issue);
    if (cyc == 2000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Slot shape: write enable must be the inverse of padding
  task automatic chk_slot(input int i, input logic [1:0] idx, input logic [1:0] c,
                          input logic nop);
    chk({slots[i].cycle_index, slots[i].cycles, slots[i].nop, slots[i].write_en},
        {idx, c, nop, ~nop});
  endtask

  // Long enough for any queued burst to drain
  task automatic settle();
    repeat (14) @(posedge mclk);
    #2;
  endtask

  task automatic t_cycles();
    logic [24:0] ops [0:10];
    logic [1:0]  ce [0:10];
    logic [10:0] pcx;
    ops = '{25'h1300000, 25'h0370000, 25'h0010000, 25'h0030000, 25'h0060000,
            25'h0070000, 25'h0ba0000, 25'h0bb0000, 25'h0be0000, 25'h0300000,
            25'h1400000};
    ce = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
    // Taken jumps, branches and returns leave the sequential path; tables and the untaken jump do not
    pcx = 11'b00000111111;
    for (int k = 0; k < 11; k++) begin
      slots.delete();
      fm.push(ops[k][23:0], ops[k][24]);
      settle();
      chk(slots.size(), ce[k]);
      chk(slots[0].pc_change, pcx[k]);
      chk(slots[0].opcode, ops[k][23:16]);
      for (int j = 0; j < ce[k]; j++) chk_slot(j, j, ce[k], j != 0);
    end
    $display("test cycles done");
  endtask

  task automatic t_skip();
    slots.delete();
    fm.push(24'ha60000, 1'b1);
    fm.push(24'h040002, 1'b0);
    fm.push(24'h000010, 1'b0);
    fm.push(24'h400000, 1'b0);
    settle();
    chk(slots.size(), 4);
    chk_slot(0, 0, 2, 0);
    chk_slot(1, 1, 3, 1);
    chk_slot(2, 2, 3, 1);
    chk_slot(3, 0, 1, 0);
    $display("test skip done");
  endtask

  task automatic t_two_word();
    slots.delete();
    fm.push(24'h040003, 1'b0);
    fm.push(24'h000045, 1'b0);
    fm.push(24'h020000, 1'b0);
    fm.push(24'h120000, 1'b0);
    fm.push(24'h001234, 1'b0);
    settle();
    chk(slots.size(), 5);
    chk_slot(0, 0, 2, 1);
    chk_slot(1, 1, 2, 0);
    chk(slots[1].operands.program_address_literal, {7'h45, 15'h0001, 1'b0});
    chk(slots[1].second_word_bad, 1'b0);
    chk(slots[3].second_word_bad, 1'b1);
    chk({slots[4].nop, slots[4].write_en}, 2'h2);
    $display("test two word done");
  endtask

  task automatic t_fields();
    slots.delete();
    fm.push(24'h405abc, 1'b0);
    fm.push(24'h40bff0, 1'b0);
    settle();
    chk(slots[0].operands.bit_position_field, 4'h5);
    chk(slots[1].operands.file_addr, 13'h1ff0);
    chk(slots[0].operands.unsigned_ten_bit_literal, 10'h0ab);
    chk(slots[1].operands.unsigned_ten_bit_literal, 10'h3ff);
    chk({slots[0].operands.acc_sel, slots[1].operands.acc_sel}, 2'h1);
    chk(slots[0].operands.default_working_register, REG_DEFAULT_WORKING_REGISTER);
    chk({slots[0].operands.mul_a, slots[0].operands.mul_b}, 8'h67);
    chk({slots[1].operands.mul_a, slots[1].operands.mul_b}, 8'h77);
    chk(slots[0].operands.x_prefetch_address.dest_reg, 4'h6);
    chk(slots[1].operands.y_prefetch_address.dest_reg, 4'h7);
    $display("test fields done");
  endtask

  task automatic stop_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    t_cycles();
    t_skip();
    t_two_word();
    t_fields();
    stop_test();
  end
endmodule

`default_nettype wire
